/* rtl/sae_engine.sv */
// Setpoint evaluation, batch sequencing and satisfaction actions.
// Assumes weight samples, standstill and time of day synchronous to clk_i.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ns
module sae_engine (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Measurement front end
    input wire logic [23:0] weight_i,
    input wire logic weight_valid_i,
    input wire logic standstill_i,
    input wire logic [16:0] tod_sec_i,
    input wire logic sec_tick_i,
    // Digital outputs and alarm
    output logic [15:0] dout_n_o,
    output logic alarm_o,
    // Action requests
    output logic clear_total_o,
    output logic clear_tare_o,
    output logic accumulate_o,
    output logic print_o,
    output logic acquire_tare_o
);
    // ==========================================
    // Functions
    // Hours, minutes, seconds to seconds
    function automatic logic [19:0] to_sec(input logic [19:0] hms);
        to_sec = 20'(hms[sae_pkg::T_HH +: 8] * sae_pkg::SEC_PER_HOUR)
               + 20'(hms[sae_pkg::T_MM +: 6] * sae_pkg::SEC_PER_MIN)
               + 20'(hms[sae_pkg::T_SS +: 6]);
    endfunction

    // Trip test of a higher or lower setpoint
    function automatic logic trip_f(input logic [2:0] k, input logic [23:0] w, input logic [23:0] v);
        trip_f = (k == sae_pkg::K_HIGHER) ? (w >= v) : (w <= v);
    endfunction

    // Limits saturate at the top of range
    function automatic logic [23:0] lim_f(input logic [31:0] d);
        lim_f = (d > 32'(sae_pkg::LIM_MAX)) ? sae_pkg::LIM_MAX : d[23:0];
    endfunction

    // ==========================================
    // Storage
    logic [14:0] cfg_r [sae_pkg::NSP];
    logic [23:0] lo_r [sae_pkg::NSP];
    logic [23:0] hi_r [sae_pkg::NSP];
    logic [21:0] link_r [sae_pkg::NSP];
    logic [14:0] osel_r [sae_pkg::NSP];
    logic [19:0] time_r [sae_pkg::NSP];
    logic [19:0] dur_r [sae_pkg::NSP];
    logic run_r;
    logic [1:0] cur_r;
    logic first_r;
    logic begin_r;
    logic [3:0] trip_r;
    logic [3:0] below_r;
    logic [3:0] within_r;
    logic [3:0] above_r;
    logic [3:0] conc_r;
    logic [3:0] tod_act_r;
    logic [3:0] tod_end_r;
    logic [19:0] tod_cnt_r [sae_pkg::NSP];
    logic [3:0] pend_r;
    logic [14:0] opt_r;
    logic prn_wait_r;
    sae_pkg::sae_act_type act_r;
    logic [31:0] prdata_r;
    logic [15:0] dout_n_r;
    logic alarm_r;

    // ==========================================
    // APB decode
    logic [7:0] a;
    logic opw;
    logic is_ctrl;
    logic is_stat;
    logic sp_ok;
    logic [1:0] sp;
    logic [2:0] rsel;
    logic [2:0] blk_off;
    logic mapped;
    logic [1:0] lvl;
    logic err;
    logic wr;
    logic restart;
    logic go;

    // Address split into window, block and word
    always_comb begin
        a = paddr_i[7:0];
        opw = paddr_i[sae_pkg::OPW_BIT];
        blk_off = a[7:5] - sae_pkg::SP_FIRST_BLK;
        sp = blk_off[1:0];
        rsel = a[4:2];
        is_ctrl = (a == sae_pkg::CTRL_OFS);
        is_stat = (a == sae_pkg::STAT_OFS);
        sp_ok = (a[7:5] >= sae_pkg::SP_FIRST_BLK) && (a[7:5] <= sae_pkg::SP_LAST_BLK)
              && (rsel <= sae_pkg::R_DUR) && (a[1:0] == 2'h0);
        mapped = (paddr_i[11:9] == 3'h0) && (is_ctrl || is_stat || sp_ok);
        lvl = cfg_r[sp][sae_pkg::F_ACCESS +: 2];
    end

    // Operator window applies access level
    always_comb begin
        err = !mapped;
        if (mapped && opw) begin
            if (pwrite_i) begin
                err = !sp_ok || (lvl != sae_pkg::AC_FULL);
            end else begin
                err = sp_ok && (lvl == sae_pkg::AC_HIDE);
            end
        end
    end

    // Zero-wait answer, error on refused access
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && err;
    assign wr = psel_i && penable_i && pwrite_i && !err;
    assign restart = wr && is_ctrl && pwdata_i[sae_pkg::CTRL_RESTART];
    assign go = wr && is_ctrl && pwdata_i[sae_pkg::CTRL_RUN] && !run_r;
    assign prdata_o = prdata_r;

    // Read data captured in the setup cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_r <= 32'h00000000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_r <= 32'h00000000;
            if (!err && is_ctrl) begin
                prdata_r <= 32'(run_r);
            end else if (!err && is_stat) begin
                prdata_r <= {8'h00, tod_act_r, conc_r, trip_r, pend_r, 3'h0, run_r, 2'h0, cur_r};
            end else if (!err) begin
                case (rsel)
                    sae_pkg::R_CFG: prdata_r <= 32'(cfg_r[sp]);
                    sae_pkg::R_LOWER: prdata_r <= 32'(lo_r[sp]);
                    sae_pkg::R_UPPER: prdata_r <= 32'(hi_r[sp]);
                    sae_pkg::R_LINK: prdata_r <= 32'(link_r[sp]);
                    sae_pkg::R_OSEL: prdata_r <= 32'(osel_r[sp]);
                    sae_pkg::R_TIME: prdata_r <= 32'(time_r[sp]);
                    sae_pkg::R_DUR: prdata_r <= 32'(dur_r[sp]);
                    default: prdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    // Control register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_r <= 1'b0;
        end else if (wr && is_ctrl) begin
            run_r <= pwdata_i[sae_pkg::CTRL_RUN];
        end
    end

    // Setpoint configuration registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < sae_pkg::NSP; i++) begin
                cfg_r[i] <= sae_pkg::CFG_RST;
                lo_r[i] <= sae_pkg::LIM_RST;
                hi_r[i] <= sae_pkg::LIM_RST;
                link_r[i] <= sae_pkg::LINK_RST;
                osel_r[i] <= sae_pkg::OSEL_RST;
                time_r[i] <= sae_pkg::HMS_RST;
                dur_r[i] <= sae_pkg::HMS_RST;
            end
        end else if (wr && sp_ok) begin
            case (rsel)
                sae_pkg::R_CFG: cfg_r[sp] <= pwdata_i[14:0];
                sae_pkg::R_LOWER: lo_r[sp] <= lim_f(pwdata_i);
                sae_pkg::R_UPPER: hi_r[sp] <= lim_f(pwdata_i);
                sae_pkg::R_LINK: link_r[sp] <= pwdata_i[21:0];
                sae_pkg::R_OSEL: osel_r[sp] <= pwdata_i[14:0];
                sae_pkg::R_TIME: time_r[sp] <= pwdata_i[19:0];
                sae_pkg::R_DUR: dur_r[sp] <= pwdata_i[19:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // Weight comparisons
    logic [2:0] ck;
    logic step_batch;
    logic step_trip;
    logic [5:0] branch;
    logic [3:0] cont_sat;
    logic [3:0] sat_ev;

    // Current step and continuous satisfaction
    always_comb begin
        ck = cfg_r[cur_r][sae_pkg::F_KIND +: 3];
        step_batch = cfg_r[cur_r][sae_pkg::F_BATCH]
                  && (ck == sae_pkg::K_HIGHER || ck == sae_pkg::K_LOWER);
        step_trip = trip_f(ck, weight_i, lo_r[cur_r]);
        branch = link_r[cur_r][sae_pkg::L_BRANCH +: 6];
        for (int i = 0; i < sae_pkg::NSP; i++) begin
            cont_sat[i] = weight_valid_i && !cfg_r[i][sae_pkg::F_BATCH]
                       && (cfg_r[i][sae_pkg::F_KIND +: 3] <= sae_pkg::K_LOWER)
                       && trip_f(cfg_r[i][sae_pkg::F_KIND +: 3], weight_i, lo_r[i]) && !trip_r[i];
            sat_ev[i] = cont_sat[i] || tod_end_r[i]
                     || (run_r && !begin_r && step_batch && weight_valid_i && step_trip
                         && cur_r == 2'(i));
        end
    end

    // Latched results of every new sample
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trip_r <= 4'h0;
            below_r <= 4'h0;
            within_r <= 4'h0;
            above_r <= 4'h0;
        end else if (weight_valid_i) begin
            for (int i = 0; i < sae_pkg::NSP; i++) begin
                trip_r[i] <= trip_f(cfg_r[i][sae_pkg::F_KIND +: 3], weight_i, lo_r[i]);
                below_r[i] <= weight_i < lo_r[i];
                within_r[i] <= weight_i >= lo_r[i] && weight_i <= hi_r[i];
                above_r[i] <= weight_i > hi_r[i];
            end
        end
    end

    // ==========================================
    // Batch sequencer
    // Steps not of batch kind are passed at once
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur_r <= 2'h0;
            first_r <= 1'b0;
            begin_r <= 1'b0;
        end else begin
            begin_r <= 1'b0;
            if (restart || go) begin
                if (restart) begin
                    cur_r <= 2'h0;
                end
                begin_r <= 1'b1;
                first_r <= 1'b1;
            end else if (run_r && !begin_r) begin
                if (!step_batch) begin
                    cur_r <= cur_r + 2'h1;
                    begin_r <= 1'b1;
                    first_r <= 1'b1;
                end else if (weight_valid_i) begin
                    first_r <= 1'b0;
                    if (step_trip) begin
                        cur_r <= cur_r + 2'h1;
                        begin_r <= 1'b1;
                        first_r <= 1'b1;
                    end else if (first_r && branch != 6'h00) begin
                        cur_r <= 2'(branch - 6'h01);
                        begin_r <= 1'b1;
                        first_r <= 1'b1;
                    end
                end
            end
        end
    end

    // Concurrent setpoints follow the beginning of other steps
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            conc_r <= 4'h0;
        end else begin
            for (int i = 0; i < sae_pkg::NSP; i++) begin
                if (cfg_r[i][sae_pkg::F_KIND +: 3] != sae_pkg::K_CONCUR || !run_r) begin
                    conc_r[i] <= 1'b0;
                end else if (begin_r && link_r[i][sae_pkg::L_END +: 6] == {4'h0, cur_r} + 6'h01) begin
                    conc_r[i] <= 1'b0;
                end else if (begin_r && link_r[i][sae_pkg::L_START +: 6] == {4'h0, cur_r} + 6'h01) begin
                    conc_r[i] <= 1'b1;
                end
            end
        end
    end

    // ==========================================
    // Time-of-day setpoints
    // Duration counted in seconds, actions at its end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tod_act_r <= 4'h0;
            tod_end_r <= 4'h0;
            for (int i = 0; i < sae_pkg::NSP; i++) begin
                tod_cnt_r[i] <= sae_pkg::HMS_RST;
            end
        end else begin
            tod_end_r <= 4'h0;
            for (int i = 0; i < sae_pkg::NSP; i++) begin
                if (cfg_r[i][sae_pkg::F_KIND +: 3] != sae_pkg::K_TOD) begin
                    tod_act_r[i] <= 1'b0;
                end else if (tod_act_r[i] && sec_tick_i) begin
                    tod_cnt_r[i] <= tod_cnt_r[i] - 20'h00001;
                    if (tod_cnt_r[i] <= 20'h00001) begin
                        tod_act_r[i] <= 1'b0;
                        tod_end_r[i] <= 1'b1;
                    end
                end else if (!tod_act_r[i] && sec_tick_i && 20'(tod_sec_i) == to_sec(time_r[i])) begin
                    tod_cnt_r[i] <= to_sec(dur_r[i]);
                    tod_act_r[i] <= to_sec(dur_r[i]) != 20'h00000;
                    tod_end_r[i] <= to_sec(dur_r[i]) == 20'h00000;
                end
            end
        end
    end

    // ==========================================
    // Satisfaction actions
    logic [3:0] pick;
    logic [1:0] pick_idx;
    logic [1:0] acc_m;
    logic [1:0] prn_m;
    logic prn_now;

    // Lowest pending setpoint is served first
    always_comb begin
        pick = 4'h0;
        pick_idx = 2'h0;
        for (int i = sae_pkg::NSP - 1; i >= 0; i--) begin
            if (pend_r[i]) begin
                pick = 4'h0;
                pick[i] = 1'b1;
                pick_idx = 2'(i);
            end
        end
        if (act_r != sae_pkg::ACT_IDLE) begin
            pick = 4'h0;
        end
        acc_m = opt_r[sae_pkg::F_ACC +: 2];
        prn_m = opt_r[sae_pkg::F_PRN +: 2];
        prn_now = act_r == sae_pkg::ACT_PRINT && (prn_m == sae_pkg::M_ON || acc_m == sae_pkg::M_ON);
    end

    // Pending events, a new event wins over its own clear
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_r <= 4'h0;
        end else begin
            pend_r <= (pend_r & ~pick) | sat_ev;
        end
    end

    // One step per cycle in fixed order
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            act_r <= sae_pkg::ACT_IDLE;
            opt_r <= sae_pkg::CFG_RST;
        end else begin
            case (act_r)
                sae_pkg::ACT_IDLE: begin
                    if (pend_r != 4'h0) begin
                        act_r <= sae_pkg::ACT_CLR_TOTAL;
                        opt_r <= cfg_r[pick_idx];
                    end
                end
                sae_pkg::ACT_CLR_TOTAL: act_r <= sae_pkg::ACT_CLR_TARE;
                sae_pkg::ACT_CLR_TARE: act_r <= sae_pkg::ACT_ACCUM;
                sae_pkg::ACT_ACCUM: act_r <= sae_pkg::ACT_PRINT;
                sae_pkg::ACT_PRINT: act_r <= sae_pkg::ACT_TARE;
                sae_pkg::ACT_TARE: act_r <= sae_pkg::ACT_IDLE;
                default: act_r <= sae_pkg::ACT_IDLE;
            endcase
        end
    end

    // Deferred print waits for standstill
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prn_wait_r <= 1'b0;
        end else if (act_r == sae_pkg::ACT_PRINT && !prn_now && prn_m == sae_pkg::M_ALT) begin
            prn_wait_r <= 1'b1;
        end else if (standstill_i) begin
            prn_wait_r <= 1'b0;
        end
    end

    // Action request pulses
    assign clear_total_o = act_r == sae_pkg::ACT_CLR_TOTAL && opt_r[sae_pkg::F_CLRTOT];
    assign clear_tare_o = act_r == sae_pkg::ACT_CLR_TARE && opt_r[sae_pkg::F_CLEAR_TARE_ON_DONE];
    assign accumulate_o = act_r == sae_pkg::ACT_ACCUM && acc_m != sae_pkg::M_OFF;
    assign print_o = prn_now || (prn_wait_r && standstill_i);
    // No regulatory gating on the tare capture
    assign acquire_tare_o = act_r == sae_pkg::ACT_TARE && opt_r[sae_pkg::F_ACQ];

    // ==========================================
    // Output mapping and alarm
    logic [15:0] out_act;
    logic alarm_nxt;
    logic lvl_on;
    logic inv;
    logic [2:0] k;
    logic [3:0] base;

    // Each setpoint of kind 0 to 3 drives its slot and bit, a checkweigh setpoint its below, within and above bits
    always_comb begin
        out_act = 16'h0000;
        alarm_nxt = 1'b0;
        lvl_on = 1'b0;
        inv = 1'b0;
        k = 3'h0;
        base = 4'h0;
        for (int i = 0; i < sae_pkg::NSP; i++) begin
            k = cfg_r[i][sae_pkg::F_KIND +: 3];
            inv = cfg_r[i][sae_pkg::F_INV];
            base = {osel_r[i][sae_pkg::O_SLOT], 3'h0};
            case (k)
                sae_pkg::K_HIGHER, sae_pkg::K_LOWER: begin
                    if (cfg_r[i][sae_pkg::F_BATCH]) begin
                        lvl_on = run_r && cur_r == 2'(i);
                    end else begin
                        lvl_on = trip_r[i];
                    end
                    alarm_nxt = alarm_nxt || (cfg_r[i][sae_pkg::F_ALARM] && (cfg_r[i][sae_pkg::F_BATCH]
                              ? lvl_on : !trip_r[i]));
                end
                sae_pkg::K_CONCUR: lvl_on = conc_r[i];
                sae_pkg::K_TOD: lvl_on = tod_act_r[i];
                default: lvl_on = 1'b0;
            endcase
            if (k == sae_pkg::K_CHK) begin
                out_act[base | {1'b0, osel_r[i][sae_pkg::O_BELOW +: 3]}] |= below_r[i] ^ inv;
                out_act[base | {1'b0, osel_r[i][sae_pkg::O_WITHIN +: 3]}] |= within_r[i] ^ inv;
                out_act[base | {1'b0, osel_r[i][sae_pkg::O_ABOVE +: 3]}] |= above_r[i] ^ inv;
            end else if (k <= sae_pkg::K_CHK) begin
                out_act[base | {1'b0, osel_r[i][sae_pkg::O_BIT +: 3]}] |= lvl_on ^ inv;
            end
        end
    end

    // Active outputs are driven low
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dout_n_r <= 16'hFFFF;
            alarm_r <= 1'b0;
        end else begin
            dout_n_r <= ~out_act;
            alarm_r <= alarm_nxt;
        end
    end

    assign dout_n_o = dout_n_r;
    assign alarm_o = alarm_r;
endmodule // sae_engine

/* rtl/sae_pkg.sv */
// Constants, register map and types of the setpoint action engine.
// Assumes one 50 MHz system clock and a 32-bit APB master.
// Notes on behaviour
// - Satisfied setpoint with clear-tare option pulses the clear-tare request.
// - Accumulate on: accumulate plus print; silent: accumulate only.
// - Print on: print at once; standstill mode: print when standstill follows.
// - Acquire-tare pulses on satisfaction, ignoring any regulatory restriction.
// - Actions run in order: clear total, clear tare, accumulate, print, tare.
// - Alarm while batch setpoint active or continuous setpoint untripped.
// - Concurrent setpoint starts when its starting setpoint (1 to 4) begins.
// - Concurrent setpoint stops when its ending setpoint begins.
// - Access levels: full, hidden, view only; refused accesses answer error.
// - Each output picked by slot number plus bit number in that slot.
// - Continuous setpoint drives its output low once tripped.
// - Batch output active from step start until condition met.
// - Batch unsatisfied at first evaluation jumps to branch; zero means none.
// - Time-of-day output held for duration; actions run when duration ends.
// - Checkweigh below bit active while weight under lower limit.
// - Checkweigh within bit active while weight between both limits.
// - Checkweigh above bit active while weight over upper limit.
// - Polarity setting inverts the output level when set.
// - Satisfied setpoint with clear-total option pulses the clear-total request.
// - Batch flag selects sequenced operation, otherwise continuous evaluation.
package sae_pkg;
    // ==========================================
    // Sizes
    localparam int NSP = 4;
    localparam int NOUT = 16;
    localparam logic [23:0] LIM_MAX = 24'h98967F;
    // ==========================================
    // Register map
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [2:0] SP_FIRST_BLK = 3'h2;
    localparam logic [2:0] SP_LAST_BLK = 3'h5;
    localparam int OPW_BIT = 8;
    localparam logic [2:0] R_CFG = 3'h0;
    localparam logic [2:0] R_LOWER = 3'h1;
    localparam logic [2:0] R_UPPER = 3'h2;
    localparam logic [2:0] R_LINK = 3'h3;
    localparam logic [2:0] R_OSEL = 3'h4;
    localparam logic [2:0] R_TIME = 3'h5;
    localparam logic [2:0] R_DUR = 3'h6;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_RESTART = 1;
    // ==========================================
    // Configuration fields
    localparam int F_KIND = 0;
    localparam int F_BATCH = 3;
    localparam int F_CLRTOT = 4;
    localparam int F_CLEAR_TARE_ON_DONE = 5;
    localparam int F_ACC = 6;
    localparam int F_PRN = 8;
    localparam int F_ACQ = 10;
    localparam int F_ALARM = 11;
    localparam int F_INV = 12;
    localparam int F_ACCESS = 13;
    localparam int L_START = 0;
    localparam int L_END = 8;
    localparam int L_BRANCH = 16;
    localparam int O_BIT = 0;
    localparam int O_SLOT = 3;
    localparam int O_BELOW = 4;
    localparam int O_WITHIN = 8;
    localparam int O_ABOVE = 12;
    localparam int T_SS = 0;
    localparam int T_MM = 6;
    localparam int T_HH = 12;
    localparam logic [19:0] SEC_PER_HOUR = 20'h00E10;
    localparam logic [19:0] SEC_PER_MIN = 20'h0003C;
    // ==========================================
    // Encodings and reset values
    localparam logic [2:0] K_HIGHER = 3'h0;
    localparam logic [2:0] K_LOWER = 3'h1;
    localparam logic [2:0] K_CONCUR = 3'h2;
    localparam logic [2:0] K_TOD = 3'h3;
    localparam logic [2:0] K_CHK = 3'h4;
    localparam logic [1:0] M_OFF = 2'h0;
    localparam logic [1:0] M_ON = 2'h1;
    localparam logic [1:0] M_ALT = 2'h2;
    localparam logic [1:0] AC_FULL = 2'h0;
    localparam logic [1:0] AC_HIDE = 2'h1;
    localparam logic [1:0] AC_VIEW = 2'h2;
    localparam logic [14:0] CFG_RST = 15'h0000;
    localparam logic [23:0] LIM_RST = 24'h000000;
    localparam logic [21:0] LINK_RST = 22'h000000;
    localparam logic [14:0] OSEL_RST = 15'h0000;
    localparam logic [19:0] HMS_RST = 20'h00000;
    // ==========================================
    // Action sequencer states
    typedef enum logic [2:0] {
        ACT_IDLE, ACT_CLR_TOTAL, ACT_CLR_TARE, ACT_ACCUM, ACT_PRINT, ACT_TARE
    } sae_act_type;
endpackage

/* tb/sae_engine_chk.sv */
// Port checker for the setpoint action engine.
// Assumes binding onto sae_engine with one clock domain.
`timescale 1ns/1ns
module sae_engine_chk (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Action requests
    input wire logic clear_total_o,
    input wire logic clear_tare_o,
    input wire logic accumulate_o,
    input wire logic acquire_tare_o
);
    // ==========
    // Properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    AST_READY: assert property (psel_i && penable_i |-> pready_o) else $error("pready low");
    AST_ERR_PHASE: assert property (pslverr_o |-> psel_i && penable_i) else $error("stray pslverr");
    AST_GLOBAL: assert property (psel_i && penable_i && pwrite_i && paddr_i[8] && paddr_i[7:0] < 8'h40
        |-> pslverr_o) else $error("global write taken");
    AST_ERR_ZERO: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0) else $error("refused data");
    AST_SEQ_LEN: assert property (clear_total_o |=> !clear_total_o [*5]) else $error("sequence short");
    AST_TARE_NEXT: assert property (clear_tare_o |=> !(clear_tare_o || acquire_tare_o)) else $error("tare");
    AST_ACC_NEXT: assert property (accumulate_o |=> !(accumulate_o || acquire_tare_o)) else $error("acc");
    AST_ACQ_PAST: assert property (acquire_tare_o |-> !$past(clear_tare_o) && !$past(acquire_tare_o))
        else $error("acquire order");
    // Main scenarios
    cover property (clear_total_o);
    cover property (acquire_tare_o);
    cover property (pslverr_o);
endmodule // sae_engine_chk
bind sae_engine sae_engine_chk u_sae_engine_chk (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .prdata_o, .pready_o, .pslverr_o, .clear_total_o, .clear_tare_o, .accumulate_o, .acquire_tare_o);

/* tb/sae_front.sv */
// Weight front end model: one sample every fourth cycle.
// Assumes the bench sets the scale level.
`timescale 1ns/1ns
module sae_front (
    // Clock, reset and level
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [23:0] level_i,
    // Samples
    output logic [23:0] weight_o,
    output logic weight_valid_o
);
    logic [1:0] cnt_r;
    // Sample strobe; data inverted outside samples
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= 2'h0;
            weight_valid_o <= 1'b0;
            weight_o <= 24'h000000;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            weight_valid_o <= (cnt_r == 2'h3);
            weight_o <= (cnt_r == 2'h3) ? level_i : ~level_i;
        end
    end
endmodule // sae_front

/* tb/test_sae_engine.sv */
// Bench for the setpoint action engine.
// Assumes sae_engine, sae_front and the bound checker.
`timescale 1ns/1ns
module test_sae_engine;
    typedef struct {logic [23:0] w; logic [2:0] d;} sae_row_type;
    sae_row_type rows [3] = '{'{24'h000032, 3'h6}, '{24'h000096, 3'h5}, '{24'h0000FA, 3'h3}};
    logic clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [23:0] level = 24'h0, weight_i;
    logic [15:0] dout_n_o;
    logic pready_o, pslverr_o, er, alarm_o, weight_valid_i;
    logic clear_total_o, clear_tare_o, accumulate_o, print_o, acquire_tare_o;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    // ==========
    // Clock, model and design
    always #10 clk_i = ~clk_i;
    sae_front u_sae_front (.clk_i, .rstn_i, .level_i(level), .weight_o(weight_i), .weight_valid_o(weight_valid_i));
    sae_engine u_sae_engine (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .weight_i, .weight_valid_i, .standstill_i(1'b0), .tod_sec_i(17'h00000),
        .sec_tick_i(1'b0), .dout_n_o, .alarm_o, .clear_total_o, .clear_tare_o, .accumulate_o, .print_o,
        .acquire_tare_o);
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            test_done();
        end
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        chk("dout_n", 16'hFFFF, dout_n_o);
        rstn_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("dout_n0", 1'b0, dout_n_o[0]);
        apb(1'b1, 12'h044, 32'h64);
        apb(1'b1, 12'h048, 32'hC8);
        apb(1'b1, 12'h050, 32'h5430);
        apb(1'b1, 12'h040, 32'(sae_pkg::K_CHK));
        foreach (rows[i]) begin
            level <= rows[i].w;
            repeat (8) @(posedge clk_i);
            chk("checkweigh", rows[i].d, dout_n_o[5:3]);
        end
        apb(1'b1, 12'h064, 32'h3E8);
        apb(1'b1, 12'h060, 32'h470);
        level <= 24'h0007D0;
        while (clear_total_o !== 1'b1) @(posedge clk_i);
        for (int i = 0; i < 5; i++) begin
            chk("actions", 5'h10 >> i, {clear_total_o, clear_tare_o, accumulate_o, print_o, acquire_tare_o});
            @(posedge clk_i);
        end
        apb(1'b1, 12'h068, 32'hFFFFFF);
        apb(1'b0, 12'h068, 32'h0);
        chk("upper", 32'h98967F, rd);
        apb(1'b1, 12'h100, 32'h1);
        chk("global_err", 1'b1, er);
        apb(1'b0, 12'h042, 32'h0);
        chk("misaligned_err", 1'b1, er);
        apb(1'b1, 12'h060, 32'h4470);
        apb(1'b1, 12'h164, 32'h5);
        chk("view_err", 1'b1, er);
        apb(1'b0, 12'h164, 32'h0);
        chk("view_data", 32'h3E8, rd);
        apb(1'b1, 12'h0A4, 32'hFFFFFF);
        apb(1'b1, 12'h0A0, 32'h808);
        apb(1'b1, 12'h080, 32'h2);
        apb(1'b1, 12'h08C, 32'h104);
        apb(1'b1, 12'h000, 32'h1);
        repeat (8) @(posedge clk_i);
        apb(1'b0, 12'h004, 32'h0);
        chk("status", 32'h42013, rd);
        chk("alarm", 1'b1, alarm_o);
        test_done();
    end
endmodule // test_sae_engine
